// ---- shared/tcs_pkg.sv ----
/*
 * tcs_pkg: constants and carrier types of the timer clock select and
 * interval timer block. Assumes a single 250 MHz system clock.
 */
package tcs_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [6:0] TCS_IDX_TMR_CFG = 7'h31;
    localparam logic [6:0] TCS_IDX_CLKIO = 7'h32;
    localparam logic [6:0] TCS_IDX_RELOAD_LO = 7'h40;
    localparam logic [6:0] TCS_IDX_RELOAD_HI = 7'h41;
    localparam logic [6:0] TCS_IDX_IRQ_STATUS = 7'h42;
    localparam logic [6:0] TCS_IDX_IRQ_MASK = 7'h43;
    localparam logic [6:0] TCS_IDX_COUNT_LO = 7'h44;
    localparam logic [6:0] TCS_IDX_COUNT_HI = 7'h45;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] TCS_TMR_CFG_RST = 8'h8f;
    localparam logic [7:0] TCS_CLKIO_RST = 8'h00;
    localparam logic [11:0] TCS_RELOAD_RST = 12'h0ff;
    localparam logic [11:0] TCS_COUNT_RST = 12'h0ff;
    localparam logic [7:0] TCS_IRQ_MASK_RST = 8'h00;

    // ************************************************************
    // field positions and codes
    // ************************************************************
    localparam int TCS_IRQ_RELOAD_BIT = 0;
    localparam int TCS_STAT_XTAL_READY_BIT = 1;
    localparam logic [1:0] TCS_SRC_OSC24 = 2'h0;
    localparam logic [1:0] TCS_SRC_EXT = 2'h1;
    localparam logic [1:0] TCS_SRC_OSC32 = 2'h2;
    localparam logic [1:0] TCS_SRC_ALT = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int TCS_CLK_MHZ = 250;
    localparam int TCS_XTAL_START_MS = 2;
    localparam int TCS_XTAL_START_CYC = TCS_XTAL_START_MS * TCS_CLK_MHZ * 1000;
    localparam int TCS_FILTER_LEN = 4;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] cap_div;
        logic [1:0] cap_sel;
        logic [1:0] itv_div;
        logic [1:0] itv_sel;
    } tcs_tmr_cfg_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic crystal_clock_select;
        logic crystal_osc_enable;
        logic clock_filter_bypass;
        logic [1:0] clock_output_source;
    } tcs_clkio_s;

    typedef enum logic {TCS_BUS_IDLE, TCS_BUS_ACK} tcs_bus_e;

endpackage

// ---- verilog/tcs_timer_clock.sv ----
/*
 * tcs_timer_clock: clock source select and dividers for the interval and
 * capture timer clocks, clock output pad select, crystal pad control and
 * the 12-bit reloading interval timer with its interrupt.
 * Assumes all clock source inputs are sampled levels synchronous to i_clk
 * and several times slower than it; registers sit on an Avalon-MM slave.
 */
// Function
// - select bit picks crystal as external source
// - enable starts crystal, disables shared pad drivers
// - crystal off: clock input from pad
// - filter bypass bit skips input noise filter
// - output pad source: 24M, ext, 32k, cpu
// - external clock: crystal if enabled and selected, else pad
// - interval source: 24M, ext, 32k, capture
// - interval prescaler divides by 1 to 4
// - 12-bit down counter reloads on terminal count
// - tick after zero spent reloading
// - interrupt raised on every reload
// - reload readable, writable while counting
// - capture source: 24M, ext, 32k
// - capture divider: 2, 4, 6 or 8
// - source change needs the current clock running
`timescale 1ns/1ns
module tcs_timer_clock
    import tcs_pkg::*;
#(
    parameter int XTAL_START_CYC = TCS_XTAL_START_CYC,
    parameter int FILTER_LEN = TCS_FILTER_LEN
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_osc24_clk,
    input wire logic i_osc32_clk,
    input wire logic i_cpu_clock,
    input wire logic i_crystal_osc_clk,
    input wire logic i_port0_bit0_in,
    output logic o_crystal_osc_enable,
    output logic o_port0_drive_disable,
    output logic o_clock_output_pad,
    output logic o_clock_output_oe,
    output logic o_capture_timer_clock,
    output logic o_interval_timer_clock,
    output logic o_irq
);

    // ************************************************************
    // register state
    // ************************************************************
    tcs_tmr_cfg_s tmr_cfg_q;
    tcs_clkio_s clkio_q;
    logic [11:0] reload_q;
    logic [11:0] count_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_mask_q;
    tcs_bus_e bus_q;
    logic [31:0] rdata_d;
    logic [6:0] idx;
    logic addr_ok;
    logic wr_now;
    logic reload_evt;
    logic xtal_ready_q;
    logic [$clog2(XTAL_START_CYC+1)-1:0] xtal_cnt_q;

    assign idx = i_avs_address[8:2];
    assign addr_ok = (i_avs_address[1:0] == 2'h0);
    assign wr_now = i_avs_write && (bus_q == TCS_BUS_ACK) && addr_ok && i_avs_byteenable[0];

    // ************************************************************
    // bus handshake: one wait cycle, answer on the second
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_q <= TCS_BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
        end
        else
        begin
            unique case (bus_q)
                TCS_BUS_IDLE:
                begin
                    if (i_avs_read || i_avs_write)
                    begin
                        bus_q <= TCS_BUS_ACK;
                        o_avs_waitrequest <= 1'b0;
                        o_avs_readdata <= rdata_d;
                    end
                end
                TCS_BUS_ACK:
                begin
                    bus_q <= TCS_BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_d = 32'h0;
        if (addr_ok)
        begin
            unique case (idx)
                TCS_IDX_TMR_CFG: rdata_d[7:0] = tmr_cfg_q;
                TCS_IDX_CLKIO: rdata_d[4:0] = clkio_q[4:0];
                TCS_IDX_RELOAD_LO: rdata_d[7:0] = reload_q[7:0];
                TCS_IDX_RELOAD_HI: rdata_d[3:0] = reload_q[11:8];
                TCS_IDX_IRQ_STATUS: rdata_d[7:0] = irq_status_q;
                TCS_IDX_IRQ_MASK: rdata_d[7:0] = irq_mask_q;
                TCS_IDX_COUNT_LO: rdata_d[7:0] = count_q[7:0];
                TCS_IDX_COUNT_HI: rdata_d[3:0] = count_q[11:8];
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tmr_cfg_q <= TCS_TMR_CFG_RST;
            clkio_q <= TCS_CLKIO_RST;
            reload_q <= TCS_RELOAD_RST;
            irq_mask_q <= TCS_IRQ_MASK_RST;
        end
        else if (wr_now)
        begin
            unique case (idx)
                TCS_IDX_TMR_CFG: tmr_cfg_q <= i_avs_writedata[7:0];
                TCS_IDX_CLKIO: clkio_q <= {3'h0, i_avs_writedata[4:0]};
                TCS_IDX_RELOAD_LO: reload_q[7:0] <= i_avs_writedata[7:0];
                TCS_IDX_RELOAD_HI: reload_q[11:8] <= i_avs_writedata[3:0];
                TCS_IDX_IRQ_MASK: irq_mask_q <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // crystal control and start-up status
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_crystal_osc_enable <= 1'b0;
            o_port0_drive_disable <= 1'b0;
            o_clock_output_oe <= 1'b1;
        end
        else
        begin
            o_crystal_osc_enable <= clkio_q.crystal_osc_enable;
            o_port0_drive_disable <= clkio_q.crystal_osc_enable;
            o_clock_output_oe <= !clkio_q.crystal_osc_enable;
        end
    end

    // informs firmware when the start-up time has elapsed
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            xtal_cnt_q <= '0;
            xtal_ready_q <= 1'b0;
        end
        else if (!clkio_q.crystal_osc_enable)
        begin
            xtal_cnt_q <= '0;
            xtal_ready_q <= 1'b0;
        end
        else if (xtal_cnt_q == ($bits(xtal_cnt_q))'(XTAL_START_CYC - 1))
        begin
            xtal_ready_q <= 1'b1;
        end
        else
        begin
            xtal_cnt_q <= xtal_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // external clock path and noise filter
    // ************************************************************
    logic ext_raw;
    logic ext_clk;
    logic [FILTER_LEN-1:0] filt_q;
    logic filt_out_q;

    // crystal only when enabled and selected, otherwise the pad input
    assign ext_raw = (clkio_q.crystal_osc_enable && clkio_q.crystal_clock_select)
        ? i_crystal_osc_clk : i_port0_bit0_in;

    // output follows input only after it has stayed stable
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            filt_q <= '0;
            filt_out_q <= 1'b0;
        end
        else
        begin
            filt_q <= {filt_q[FILTER_LEN-2:0], ext_raw};
            if (&filt_q)
            begin
                filt_out_q <= 1'b1;
            end
            else if (~|filt_q)
            begin
                filt_out_q <= 1'b0;
            end
        end
    end

    assign ext_clk = clkio_q.clock_filter_bypass ? ext_raw : filt_out_q;

    // ************************************************************
    // clock output pad
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_clock_output_pad <= 1'b0;
        end
        else
        begin
            unique case (clkio_q.clock_output_source)
                TCS_SRC_OSC24: o_clock_output_pad <= i_osc24_clk;
                TCS_SRC_EXT: o_clock_output_pad <= ext_clk;
                TCS_SRC_OSC32: o_clock_output_pad <= i_osc32_clk;
                TCS_SRC_ALT: o_clock_output_pad <= i_cpu_clock;
            endcase
        end
    end

    // ************************************************************
    // capture timer clock: select, divide by 2/4/6/8
    // ************************************************************
    logic [1:0] cap_sel_q;
    logic [1:0] cap_div_q;
    logic cap_src;
    logic cap_prev_q;
    logic cap_rise;
    logic [1:0] cap_cnt_q;

    always_comb
    begin
        unique case (cap_sel_q)
            TCS_SRC_OSC24: cap_src = i_osc24_clk;
            TCS_SRC_EXT: cap_src = ext_clk;
            TCS_SRC_OSC32: cap_src = i_osc32_clk;
            TCS_SRC_ALT: cap_src = 1'b0;
        endcase
    end

    assign cap_rise = cap_src && !cap_prev_q;

    // half period is div+1 source edges; new setting only at period end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cap_prev_q <= 1'b0;
            cap_cnt_q <= 2'h0;
            o_capture_timer_clock <= 1'b0;
            cap_sel_q <= TCS_TMR_CFG_RST[5:4];
            cap_div_q <= TCS_TMR_CFG_RST[7:6];
        end
        else
        begin
            cap_prev_q <= cap_src;
            if (cap_rise)
            begin
                if (cap_cnt_q == cap_div_q)
                begin
                    cap_cnt_q <= 2'h0;
                    o_capture_timer_clock <= !o_capture_timer_clock;
                    if (o_capture_timer_clock)
                    begin
                        cap_sel_q <= tmr_cfg_q.cap_sel;
                        cap_div_q <= tmr_cfg_q.cap_div;
                    end
                end
                else
                begin
                    cap_cnt_q <= cap_cnt_q + 2'h1;
                end
            end
        end
    end

    // ************************************************************
    // interval timer clock: select, prescale by 1..4
    // ************************************************************
    logic [1:0] itv_sel_q;
    logic [1:0] itv_div_q;
    logic itv_src;
    logic itv_prev_q;
    logic itv_rise;
    logic [1:0] itv_cnt_q;
    logic itv_tick;

    always_comb
    begin
        unique case (itv_sel_q)
            TCS_SRC_OSC24: itv_src = i_osc24_clk;
            TCS_SRC_EXT: itv_src = ext_clk;
            TCS_SRC_OSC32: itv_src = i_osc32_clk;
            TCS_SRC_ALT: itv_src = o_capture_timer_clock;
        endcase
    end

    assign itv_rise = itv_src && !itv_prev_q;
    assign itv_tick = itv_rise && (itv_cnt_q == itv_div_q);

    // a stopped source never reaches the boundary, so a change waits
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            itv_prev_q <= 1'b0;
            itv_cnt_q <= 2'h0;
            itv_sel_q <= TCS_TMR_CFG_RST[1:0];
            itv_div_q <= TCS_TMR_CFG_RST[3:2];
            o_interval_timer_clock <= 1'b0;
        end
        else
        begin
            itv_prev_q <= itv_src;
            o_interval_timer_clock <= itv_tick;
            if (itv_tick)
            begin
                itv_cnt_q <= 2'h0;
                itv_sel_q <= tmr_cfg_q.itv_sel;
                itv_div_q <= tmr_cfg_q.itv_div;
            end
            else if (itv_rise)
            begin
                itv_cnt_q <= itv_cnt_q + 2'h1;
            end
        end
    end

    // ************************************************************
    // interval down counter
    // ************************************************************
    assign reload_evt = itv_tick && (count_q == 12'h000);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count_q <= TCS_COUNT_RST;
        end
        else if (itv_tick)
        begin
            if (count_q == 12'h000)
            begin
                count_q <= reload_q;
            end
            else
            begin
                count_q <= count_q - 12'h001;
            end
        end
    end

    // ************************************************************
    // interrupt status, mask and output
    // ************************************************************
    logic [7:0] irq_set;
    logic [7:0] irq_clr;

    always_comb
    begin
        irq_set = 8'h00;
        irq_set[TCS_IRQ_RELOAD_BIT] = reload_evt;
        irq_clr = 8'h00;
        if (wr_now && idx == TCS_IDX_IRQ_STATUS)
        begin
            irq_clr = i_avs_writedata[7:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_status_q <= 8'h00;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status_q <= ((irq_status_q & ~irq_clr) | irq_set) & 8'h01;
            irq_status_q[TCS_STAT_XTAL_READY_BIT] <= xtal_ready_q;
            o_irq <= |(irq_status_q & irq_mask_q & 8'h01);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_reload_value: assert property (@(posedge i_clk) disable iff (i_rst)
        reload_evt |=> count_q == $past(reload_q))
        else $error("counter did not load reload value after zero");
    a_count_down: assert property (@(posedge i_clk) disable iff (i_rst)
        itv_tick && count_q != 12'h000 |=> count_q == $past(count_q) - 12'h001)
        else $error("counter did not step down by one");
    a_count_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !itv_tick |=> $stable(count_q))
        else $error("counter moved without a tick");
    a_reload_irq: assert property (@(posedge i_clk) disable iff (i_rst)
        reload_evt && irq_mask_q[0] |=> irq_status_q[0] ##1 (o_irq == $past(irq_mask_q[0])))
        else $error("reload did not raise the interrupt");
    a_pad_release: assert property (@(posedge i_clk) disable iff (i_rst)
        clkio_q.crystal_osc_enable |=> o_port0_drive_disable && !o_clock_output_oe)
        else $error("shared pad drivers not disabled");
    a_cap_stopped: assert property (@(posedge i_clk) disable iff (i_rst)
        cap_sel_q == TCS_SRC_ALT |=> $stable(o_capture_timer_clock))
        else $error("stopped capture clock toggled");
    a_cap_no_glitch: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(cap_sel_q) || $changed(cap_div_q) |-> $fell(o_capture_timer_clock))
        else $error("capture setting changed mid period");
    a_clock_output_pad_osc24: assert property (@(posedge i_clk) disable iff (i_rst)
        clkio_q.clock_output_source == TCS_SRC_OSC24 |=> o_clock_output_pad == $past(i_osc24_clk))
        else $error("clock output pad not from 24 MHz source");
    a_bus_answer: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_avs_read || i_avs_write) && bus_q == TCS_BUS_IDLE |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");

    c_reload: cover property (@(posedge i_clk) disable iff (i_rst) reload_evt);
    c_irq: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
    c_cap_switch: cover property (@(posedge i_clk) disable iff (i_rst) $changed(cap_sel_q));

endmodule

// ---- tb/tcs_src_model.sv ----
/*
 * tcs_src_model: oscillators, cpu clock, crystal and the shared pad input.
 * Assumes the bench clock; every level changes just after its rising edge.
 */
`timescale 1ns/1ns
module tcs_src_model #(parameter int START = 20)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_xtal_en,
    output logic [4:0] o_src
);
    logic [7:0] t_q;
    int up_q;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            t_q <= 8'h00;
            up_q <= 0;
        end
        else
        begin
            t_q <= t_q + 8'h01;
            up_q <= i_xtal_en ? up_q + 1 : 0;
        end
    end
    // crystal, cpu, 32k, pad, 24m; crystal stays low until warmed up
    assign o_src = {(up_q > START) & t_q[2], t_q[4], t_q[5], t_q[3], t_q[1]};
endmodule

// ---- tb/testbench.sv ----
/*
 * testbench: drives the timer clock block over Avalon-MM, checks reads
 * through a queue and measures the generated clocks. Assumes tcs_src_model.
 */
`timescale 1ns/1ns
module testbench
    import tcs_pkg::*;
;
    logic clk, rst, rd, wr, avs_wait, xen, pdis, pad_o, pad_oe, cap, itv, irq;
    logic [8:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [4:0] src;
    logic [7:0] v, e, m;
    logic [7:0] exp_q[$], msk_q[$];
    int num_errors, samples_checked, tick_cnt, n, t0, r;

    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    tcs_src_model #(.START(20)) i_src (.i_clk(clk), .i_rst(rst), .i_xtal_en(xen), .o_src(src));

    tcs_timer_clock #(.XTAL_START_CYC(20), .FILTER_LEN(4)) i_dut (.i_clk(clk), .i_rst(rst),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(avs_wait),
        .i_osc24_clk(src[0]), .i_osc32_clk(src[2]), .i_cpu_clock(src[3]),
        .i_crystal_osc_clk(src[4]), .i_port0_bit0_in(src[1]), .o_crystal_osc_enable(xen),
        .o_port0_drive_disable(pdis), .o_clock_output_pad(pad_o), .o_clock_output_oe(pad_oe),
        .o_capture_timer_clock(cap), .o_interval_timer_clock(itv), .o_irq(irq));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task give_verdict;
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask

    task fail;
        num_errors++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask

    function automatic logic [8:0] ra(input logic [6:0] i);
        return {i, 2'b00};
    endfunction

    task bus(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [3:0] b,
             input logic [7:0] x, input logic [7:0] xm);
        int k;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        be <= b;
        if (!w)
        begin
            exp_q.push_back(x);
            msk_q.push_back(xm);
        end
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk);
            if (avs_wait === 1'b0)
                break;
        end
        rd <= 0;
        wr <= 0;
        if (k == 50)
            fail();
    endtask

    task wr_r(input logic [8:0] a, input logic [7:0] d);
        bus(1, a, d, 4'hf, 8'h00, 8'h00);
    endtask

    task rd_r(input logic [8:0] a, input logic [7:0] x, input logic [7:0] xm);
        bus(0, a, 8'h00, 4'hf, x, xm);
    endtask

    // read data taken at the edge where waitrequest is low
    always @(posedge clk)
    begin
        if (itv === 1'b1)
            tick_cnt <= tick_cnt + 1;
        if (rd === 1'b1 && avs_wait === 1'b0)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(rdata & {24'hffffff, m}, {24'h0, e & m});
        end
    end

    // cycles between two rises of the capture (w=1) or interval (w=0) clock
    task gap(input bit w, output int g);
        logic l, s;
        int k, rises;
        l = 1;
        g = 0;
        rises = 0;
        for (k = 0; k < 3000; k++)
        begin
            @(posedge clk);
            s = w ? cap : itv;
            if (s === 1'b1 && l === 1'b0)
                rises++;
            if (rises == 2)
                return;
            if (rises == 1)
                g++;
            l = s;
        end
        fail();
    endtask

    task wait_irq;
        int k;
        repeat (3) @(posedge clk);
        for (k = 0; k < 5000; k++)
        begin
            @(posedge clk);
            if (irq === 1'b1)
                return;
        end
        fail();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1;
        rd = 0;
        wr = 0;
        addr = 0;
        wdata = 0;
        be = 4'hf;
        void'($urandom(10876));
        repeat (5) @(posedge clk);
        rst <= 0;
        rd_r(ra(TCS_IDX_TMR_CFG), 8'h8f, 8'hff);
        rd_r(ra(TCS_IDX_CLKIO), 8'h00, 8'hff);
        rd_r(ra(TCS_IDX_RELOAD_LO), 8'hff, 8'hff);
        rd_r(ra(TCS_IDX_RELOAD_HI), 8'h00, 8'hff);
        rd_r(ra(TCS_IDX_IRQ_MASK), 8'h00, 8'hff);
        rd_r(ra(7'h7f), 8'h00, 8'hff);
        rd_r(ra(TCS_IDX_TMR_CFG) | 9'h001, 8'h00, 8'hff);
        v = 8'($urandom) & 8'hdf;
        bus(1, ra(TCS_IDX_TMR_CFG), v, 4'he, 8'h00, 8'h00);
        rd_r(ra(TCS_IDX_TMR_CFG), 8'h8f, 8'hff);
        wr_r(ra(TCS_IDX_TMR_CFG), v);
        rd_r(ra(TCS_IDX_TMR_CFG), v, 8'hff);
        wr_r(ra(TCS_IDX_RELOAD_LO), ~v);
        rd_r(ra(TCS_IDX_RELOAD_LO), ~v, 8'hff);
        for (r = 0; r < 4; r++)
        begin
            wr_r(ra(TCS_IDX_TMR_CFG), {4'h8, r[1:0], 2'h0});
            gap(0, n);
            gap(0, n);
            chk(32'(n), 32'((r + 1) * 4));
        end
        for (r = 1; r < 4; r++)
        begin
            wr_r(ra(TCS_IDX_TMR_CFG), 8'(r));
            gap(0, n);
            gap(0, n);
            chk(32'(n), 32'(r == 1 ? 16 : (r == 2 ? 64 : 8)));
        end
        for (r = 0; r < 4; r++)
        begin
            wr_r(ra(TCS_IDX_TMR_CFG), {r[1:0], 6'h00});
            gap(1, n);
            gap(1, n);
            chk(32'(n), 32'(8 * (r + 1)));
        end
        for (r = 0; r < 3; r++)
        begin
            wr_r(ra(TCS_IDX_TMR_CFG), {2'h0, r[1:0], 4'h0});
            gap(1, n);
            gap(1, n);
            chk(32'(n), 32'(r == 0 ? 8 : (r == 1 ? 32 : 128)));
        end
        wr_r(ra(TCS_IDX_CLKIO), 8'h08);
        repeat (2) @(posedge clk);
        chk({29'h0, xen, pdis, pad_oe}, 32'h6);
        repeat (30) @(posedge clk);
        rd_r(ra(TCS_IDX_IRQ_STATUS), 8'h02, 8'h02);
        wr_r(ra(TCS_IDX_CLKIO), 8'h1c);
        wr_r(ra(TCS_IDX_TMR_CFG), 8'h10);
        gap(1, n);
        gap(1, n);
        chk(32'(n), 32'h10);
        wr_r(ra(TCS_IDX_CLKIO), 8'h0c);
        gap(1, n);
        gap(1, n);
        chk(32'(n), 32'h20);
        wr_r(ra(TCS_IDX_CLKIO), 8'h04);
        repeat (2) @(posedge clk);
        chk({29'h0, xen, pdis, pad_oe}, 32'h1);
        for (r = 0; r < 4; r++)
        begin
            wr_r(ra(TCS_IDX_CLKIO), 8'h04 | 8'(r));
            repeat (8) @(posedge clk);
            v[0] = src[r];
            for (n = 0; n < 40; n++)
            begin
                @(posedge clk);
                chk(32'(pad_o), 32'(v[0]));
                v[0] = src[r];
            end
        end
        r = 2 + int'($urandom % 4);
        wr_r(ra(TCS_IDX_RELOAD_LO), 8'(r));
        wr_r(ra(TCS_IDX_RELOAD_HI), 8'h00);
        wr_r(ra(TCS_IDX_IRQ_MASK), 8'h01);
        wr_r(ra(TCS_IDX_IRQ_STATUS), 8'h01);
        wait_irq();
        t0 = tick_cnt;
        wr_r(ra(TCS_IDX_IRQ_STATUS), 8'h01);
        wait_irq();
        chk(32'(tick_cnt - t0), 32'(r + 1));
        wr_r(ra(TCS_IDX_IRQ_MASK), 8'h00);
        wr_r(ra(TCS_IDX_IRQ_STATUS), 8'h01);
        repeat (40) @(posedge clk);
        chk(32'(irq), 32'h0);
        rd_r(ra(TCS_IDX_IRQ_STATUS), 8'h01, 8'h01);
        wr_r(ra(TCS_IDX_TMR_CFG), 8'h30);
        repeat (100) @(posedge clk);
        v[0] = cap;
        t0 = 0;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            if (cap !== v[0])
                t0++;
        end
        chk(32'(t0), 32'h0);
        give_verdict();
    end
endmodule
